// ===== swdt_params.svh
/*
 Constants for the software-stoppable watchdog: mode byte fields,
 service key, read-back value, period exponents and tick dividers.
 Assumes a 20 MHz core clock feeding every divider.
*/
`ifndef SWDT_PARAMS_SVH
`define SWDT_PARAMS_SVH

`define SWDT_CORE_KHZ 20000
`define SWDT_OSC_KHZ 480
`define SWDT_HS_KHZ 10000
`define SWDT_OSC_DIV ((`SWDT_CORE_KHZ + `SWDT_OSC_KHZ - 1) / `SWDT_OSC_KHZ)
`define SWDT_HS_DIV ((`SWDT_CORE_KHZ + `SWDT_HS_KHZ - 1) / `SWDT_HS_KHZ)
`define SWDT_DIV_W 6
`define SWDT_CNT_W 20
`define SWDT_LIM_W 21
`define SWDT_EXP_W 5
`define SWDT_SVC_KEY 8'hac
`define SWDT_SVC_READ 8'h9a
`define SWDT_CLK_HI_BIT 4
`define SWDT_CLK_LO_BIT 3
`define SWDT_PER_MSB 2
`define SWDT_PER_RESET 3'h7
`define SWDT_OSC_BASE_EXP 5'h0b
`define SWDT_HS_BASE_EXP 5'h0d

`endif

// ===== swdt_pkg.sv
/*
 Types for the software-stoppable watchdog.
 Assumes swdt_params.svh sits in the same folder.
*/
`default_nettype none
package swdt_pkg;
   typedef enum {SWDT_RUN, SWDT_HOLD, SWDT_SETTLE} swdt_state_t;
   typedef enum {SWDT_CLK_OSC, SWDT_CLK_HS} swdt_clk_t;
endpackage
`default_nettype wire

// ===== swdt_tick_div.sv
/*
 Divider that turns the core clock into a one-cycle enable pulse.
 Assumes DIV is at least 1 and fits in the counter width.
*/
`default_nettype none
`include "swdt_params.svh"
module swdt_tick_div #(
   parameter int DIV = 2
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // Tick out
   output logic o_tick
);
   localparam logic [`SWDT_DIV_W-1:0] LAST = `SWDT_DIV_W'(DIV - 1);
   logic [`SWDT_DIV_W-1:0] cnt_q;

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         cnt_q <= '0;
      end else if (cnt_q == LAST) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + `SWDT_DIV_W'(1);
      end
   end

   assign o_tick = (cnt_q == LAST);
endmodule // swdt_tick_div
`default_nettype wire

// ===== swdt_top.sv
/*
 Watchdog timer whose count clock is the internal oscillator or the
 high-speed clock, with HALT/STOP suspension and settle wait.
 Assumes all inputs come from CPU-side logic on i_core_clk; writes are
 one-cycle strobes.
*/
`default_nettype none
`include "swdt_params.svh"
module swdt_top
   import swdt_pkg::*;
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // Mode register write
   input wire logic i_mode_wr,
   input wire logic [7:0] i_mode_wdata,
   // Service register access
   input wire logic i_svc_wr,
   input wire logic i_svc_bit_access,
   input wire logic [7:0] i_svc_wdata,
   output logic [7:0] o_svc_rdata,
   // Power modes and clocks
   input wire logic i_halt,
   input wire logic i_stop,
   input wire logic i_cpu_clk_hs,
   input wire logic i_osc_settled,
   // Status
   output logic o_wdt_reset,
   output logic o_counting,
   output logic o_stopped,
   output logic [`SWDT_CNT_W-1:0] o_count
);
   logic osc_tick;
   logic hs_tick;
   logic mode_written_q;
   logic stopped_q;
   swdt_clk_t clk_sel_q;
   logic [`SWDT_PER_MSB:0] period_q;
   swdt_state_t state_q;
   logic wait_cpu_osc_q;
   logic stop_seen_q;
   logic fault_pend_q;
   logic [`SWDT_CNT_W-1:0] cnt_q;
   logic rst_q;
   logic tick;
   logic cnt_en;
   logic [`SWDT_EXP_W-1:0] exp_w;
   logic [`SWDT_LIM_W-1:0] lim_w;
   logic overflow;
   logic key_ok;
   logic fault;
   logic fault_now;

   // Count clock enables
   swdt_tick_div #(.DIV(`SWDT_OSC_DIV)) u_osc_div (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .o_tick(osc_tick)
   );
   swdt_tick_div #(.DIV(`SWDT_HS_DIV)) u_hs_div (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .o_tick(hs_tick)
   );

   // Mode register, write-once; bits 7:5 are not stored
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         mode_written_q <= 1'b0;
         stopped_q <= 1'b0;
         clk_sel_q <= SWDT_CLK_OSC;
         period_q <= `SWDT_PER_RESET;
      end else if (i_mode_wr && !mode_written_q && !stopped_q) begin
         mode_written_q <= 1'b1;
         stopped_q <= i_mode_wdata[`SWDT_CLK_HI_BIT];
         clk_sel_q <= i_mode_wdata[`SWDT_CLK_LO_BIT] ? SWDT_CLK_HS : SWDT_CLK_OSC;
         period_q <= i_mode_wdata[`SWDT_PER_MSB:0];
      end else if (i_mode_wr) begin
         mode_written_q <= 1'b1;
      end
   end

   // Power-mode sequencing
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         state_q <= SWDT_RUN;
         wait_cpu_osc_q <= 1'b0;
         stop_seen_q <= 1'b0;
      end else begin
         case (state_q)
            SWDT_RUN: begin
               if (i_halt || i_stop) begin
                  state_q <= SWDT_HOLD;
                  wait_cpu_osc_q <= !i_cpu_clk_hs;
                  stop_seen_q <= i_stop;
               end
            end
            SWDT_HOLD: begin
               if (i_stop) begin
                  wait_cpu_osc_q <= !i_cpu_clk_hs;
                  stop_seen_q <= 1'b1;
               end
               if (!i_halt && !i_stop) begin
                  // Only an exit with high-speed counting after a STOP since the last RUN waits; a HALT entered from RUN never does
                  if (clk_sel_q == SWDT_CLK_HS && stop_seen_q && !i_osc_settled
                     && !(wait_cpu_osc_q && i_cpu_clk_hs)) begin
                     state_q <= SWDT_SETTLE;
                  end else begin
                     state_q <= SWDT_RUN;
                  end
               end
            end
            SWDT_SETTLE: begin
               if (i_halt || i_stop) begin
                  state_q <= SWDT_HOLD;
               end else if (i_osc_settled || (wait_cpu_osc_q && i_cpu_clk_hs)) begin
                  state_q <= SWDT_RUN;
               end
            end
            default: begin
               state_q <= SWDT_RUN;
            end
         endcase
      end
   end

   // Count enable and period
   assign tick = (clk_sel_q == SWDT_CLK_HS) ? hs_tick : osc_tick;
   assign cnt_en = tick && !stopped_q && state_q == SWDT_RUN && !i_halt && !i_stop;
   assign exp_w = ((clk_sel_q == SWDT_CLK_HS) ? `SWDT_HS_BASE_EXP : `SWDT_OSC_BASE_EXP)
      + `SWDT_EXP_W'(period_q);
   assign lim_w = (`SWDT_LIM_W'(1) << exp_w) - `SWDT_LIM_W'(1);
   // A correct-key service write or a mode write in the same cycle wins over the overflow
   assign overflow = cnt_en && !i_mode_wr && !key_ok && (cnt_q == lim_w[`SWDT_CNT_W-1:0]);

   // Fault decode
   assign key_ok = i_svc_wr && !i_svc_bit_access && i_svc_wdata == `SWDT_SVC_KEY;
   assign fault = !stopped_q && ((i_mode_wr && mode_written_q)
      || (i_svc_wr && !key_ok));
   // Faults while suspended wait for the count clock to come back
   assign fault_now = state_q == SWDT_RUN && !i_halt && !i_stop;

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         fault_pend_q <= 1'b0;
      end else if (fault && !fault_now) begin
         fault_pend_q <= 1'b1;
      end else if (fault_now || stopped_q) begin
         fault_pend_q <= 1'b0;
      end
   end

   // Counter
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         cnt_q <= '0;
      end else if (i_mode_wr) begin
         cnt_q <= '0;
      end else if (key_ok) begin
         cnt_q <= '0;
      end else if (overflow) begin
         cnt_q <= '0;
      end else if (cnt_en) begin
         cnt_q <= cnt_q + `SWDT_CNT_W'(1);
      end
   end

   // Internal reset pulse
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         rst_q <= 1'b0;
      end else begin
         rst_q <= overflow || (fault && fault_now) || (fault_pend_q && fault_now && !stopped_q);
      end
   end

   assign o_wdt_reset = rst_q;
   assign o_svc_rdata = `SWDT_SVC_READ;
   assign o_counting = !stopped_q && state_q == SWDT_RUN;
   assign o_stopped = stopped_q;
   assign o_count = cnt_q;

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);

   AST_RESET_CLK: assert property ($rose(i_rst_n) |-> clk_sel_q == SWDT_CLK_OSC && period_q == `SWDT_PER_RESET)
      else $error("Reset state is not oscillator with longest period");
   AST_MODE_CLEAR: assert property (i_mode_wr |=> cnt_q == '0)
      else $error("Mode write did not clear counter");
   AST_KEY_CLEAR: assert property (key_ok && !i_mode_wr |=> cnt_q == '0 && !o_wdt_reset)
      else $error("Key write did not clear counter cleanly");
   AST_STOPPED_QUIET: assert property (stopped_q && !fault_pend_q |=> !o_wdt_reset)
      else $error("Stopped watchdog raised reset");
   AST_HALT_HOLD: assert property ((i_halt || i_stop) && !i_mode_wr && !key_ok |=> $stable(cnt_q))
      else $error("Counter moved while suspended");
   AST_OVF_RESET: assert property (overflow |=> o_wdt_reset ##1 cnt_q <= `SWDT_CNT_W'(1))
      else $error("Overflow did not reset");
   AST_BAD_KEY: assert property (i_svc_wr && !key_ok && !stopped_q && fault_now |=> o_wdt_reset)
      else $error("Wrong key did not reset");
   AST_SECOND_MODE: assert property (i_mode_wr && mode_written_q && !stopped_q && fault_now |=> o_wdt_reset)
      else $error("Second mode write did not reset");
   AST_SETTLE_WAIT: assert property (state_q == SWDT_SETTLE && !i_osc_settled && !(wait_cpu_osc_q && i_cpu_clk_hs)
      |=> state_q != SWDT_RUN)
      else $error("Counting resumed before settling");
   AST_CPU_SWITCH: assert property (state_q == SWDT_SETTLE && wait_cpu_osc_q && i_cpu_clk_hs && !i_halt && !i_stop
      |=> state_q == SWDT_RUN)
      else $error("CPU switch did not resume counting");
   AST_READ_BACK: assert property (o_svc_rdata == `SWDT_SVC_READ)
      else $error("Service read value wrong");
   AST_HALT_RESUME: assert property (state_q == SWDT_HOLD && !stop_seen_q && !i_halt && !i_stop
      |=> state_q == SWDT_RUN)
      else $error("Counting did not resume after HALT");
   AST_OSC_RESUME: assert property (state_q == SWDT_HOLD && clk_sel_q == SWDT_CLK_OSC && !i_halt && !i_stop
      |=> state_q == SWDT_RUN)
      else $error("Oscillator count clock did not resume at once");

   COV_OVERFLOW: cover property (overflow);
   COV_SETTLE: cover property (state_q == SWDT_SETTLE ##1 state_q == SWDT_RUN);
   COV_STOPPED: cover property ($rose(stopped_q));
   COV_PENDING: cover property ($rose(fault_pend_q));
endmodule // swdt_top
`default_nettype wire

// ===== swdt_cpu_model.sv
/*
 CPU-side model for the watchdog: byte writes to the mode and service
 registers, and the power-mode and clock-status levels.
 Assumes the bench calls its tasks; everything changes at the falling edge.
*/
`default_nettype none
module swdt_cpu_model (
   // Clock
   input wire logic i_core_clk,
   // Register writes
   output logic o_mode_wr,
   output logic [7:0] o_mode_wdata,
   output logic o_svc_wr,
   output logic o_svc_bit,
   output logic [7:0] o_svc_wdata,
   // Power modes and clocks
   output logic o_halt,
   output logic o_stop,
   output logic o_cpu_hs,
   output logic o_settled
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {o_mode_wr, o_svc_wr, o_svc_bit, o_halt, o_stop, o_cpu_hs, o_settled} = 7'h01;
      o_mode_wdata = 8'h00;
      o_svc_wdata = 8'h00;
   end
   // Top bits always 011; idle data inverted so stale bytes are not seen
   task automatic mode_wr(input logic [4:0] f);
      @(negedge i_core_clk);
      o_mode_wdata = {3'h3, f};
      o_mode_wr = 1'b1;
      @(negedge i_core_clk);
      o_mode_wr = 1'b0;
      o_mode_wdata = ~o_mode_wdata;
   endtask
   task automatic svc_wr(input logic [7:0] d, input logic b);
      @(negedge i_core_clk);
      o_svc_wdata = d;
      o_svc_bit = b;
      o_svc_wr = 1'b1;
      @(negedge i_core_clk);
      o_svc_wr = 1'b0;
      o_svc_bit = 1'b0;
      o_svc_wdata = ~o_svc_wdata;
   endtask
   // Levels: halt, stop, cpu on high-speed clock, oscillator settled
   task automatic pwr(input logic [3:0] v);
      @(negedge i_core_clk);
      {o_halt, o_stop, o_cpu_hs, o_settled} = v;
   endtask
endmodule // swdt_cpu_model
`default_nettype wire

// ===== testbench.sv
/*
 Self-checking bench for the stoppable watchdog.
 Assumes swdt_top and swdt_cpu_model; 20 MHz clock, sync active-low reset.
*/
`default_nettype none
module testbench;
   import swdt_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_core_clk = 1'b0;
   logic i_rst_n;
   wire logic mode_wr, svc_wr, svc_bit, halt, stop, cpu_hs, settled;
   wire logic [7:0] mode_wdata, svc_wdata;
   wire logic [7:0] o_svc_rdata;
   wire logic o_wdt_reset, o_counting, o_stopped;
   wire logic [19:0] o_count;
   logic [19:0] c;
   int n_mismatch = 0, n_compared = 0, n_rst = 0, r, cyc = 0;
   swdt_cpu_model u_cpu (.i_core_clk(i_core_clk), .o_mode_wr(mode_wr), .o_mode_wdata(mode_wdata),
      .o_svc_wr(svc_wr), .o_svc_bit(svc_bit), .o_svc_wdata(svc_wdata), .o_halt(halt),
      .o_stop(stop), .o_cpu_hs(cpu_hs), .o_settled(settled));
   swdt_top u_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_mode_wr(mode_wr),
      .i_mode_wdata(mode_wdata), .i_svc_wr(svc_wr), .i_svc_bit_access(svc_bit),
      .i_svc_wdata(svc_wdata), .o_svc_rdata(o_svc_rdata), .i_halt(halt), .i_stop(stop),
      .i_cpu_clk_hs(cpu_hs), .i_osc_settled(settled), .o_wdt_reset(o_wdt_reset),
      .o_counting(o_counting), .o_stopped(o_stopped), .o_count(o_count));
   initial begin
      forever #25 i_core_clk = ~i_core_clk;
   end
   // Pulses are one cycle, so a counter is the only safe way to see them
   // Sampled mid-cycle, where the registered pulse has settled
   always @(negedge i_core_clk) begin
      if (o_wdt_reset === 1'b1) begin
         n_rst++;
      end
      cyc++;
      if (cyc == 30000) begin
         n_mismatch++;
         end_sim();
      end
   end
   task automatic nc(input int n);
      repeat (n) @(negedge i_core_clk);
   endtask
   task automatic check(input logic [19:0] s, input logic [19:0] e);
      n_compared++;
      if (s !== e) begin
         n_mismatch++;
         $display("mismatch t=%0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic end_sim();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      i_rst_n = 1'b0;
      nc(5);
      i_rst_n = 1'b1;
      nc(1);
      check(o_count, 0);
      check(o_counting, 1);
      check(o_svc_rdata, 8'h9a);
      nc(100);
      check(o_count > 0 && o_count < 4, 1);
      u_cpu.svc_wr(8'hac, 1'b0);
      check(o_count, 0);
      u_cpu.mode_wr(5'h08);
      check(o_count, 0);
      nc(100);
      check(o_count > 45 && o_count < 55, 1);
      u_cpu.pwr(4'hb);
      nc(2);
      c = o_count;
      check(o_counting, 0);
      nc(40);
      check(o_count, c);
      u_cpu.pwr(4'h3);
      nc(3);
      check(o_counting && o_count >= c && o_count < c + 8, 1);
      u_cpu.pwr(4'h6);
      nc(20);
      c = o_count;
      u_cpu.pwr(4'h2);
      nc(30);
      check(o_count, c);
      u_cpu.pwr(4'h3);
      nc(3);
      check(o_counting, 1);
      u_cpu.pwr(4'h4);
      nc(20);
      u_cpu.pwr(4'h0);
      nc(30);
      check(o_counting, 0);
      u_cpu.pwr(4'h2);
      nc(3);
      check(o_counting, 1);
      u_cpu.pwr(4'h3);
      // Wrong key during HALT is held back until counting resumes
      u_cpu.pwr(4'hb);
      r = n_rst;
      u_cpu.svc_wr(8'h00, 1'b0);
      nc(5);
      check(20'(n_rst - r), 0);
      u_cpu.pwr(4'h3);
      nc(3);
      check(20'(n_rst - r), 1);
      // Wrong key, bit access with the key, second mode write
      for (int k = 0; k < 3; k++) begin
         r = n_rst;
         if (k == 0) u_cpu.svc_wr(8'h00, 1'b0);
         else if (k == 1) u_cpu.svc_wr(8'hac, 1'b1);
         else u_cpu.mode_wr(5'h07);
         nc(2);
         check(20'(n_rst - r), 1);
      end
      // Still period code 0 on high-speed: 2^13 ticks of 2 cycles
      u_cpu.svc_wr(8'hac, 1'b0);
      r = n_rst;
      nc(16300);
      check(20'(n_rst - r), 0);
      nc(200);
      check(20'(n_rst - r), 1);
      i_rst_n = 1'b0;
      nc(5);
      i_rst_n = 1'b1;
      u_cpu.pwr(4'h6);
      nc(10);
      u_cpu.pwr(4'h2);
      nc(3);
      check(o_counting, 1);
      u_cpu.mode_wr(5'h10);
      nc(1);
      check(o_stopped, 1);
      check(o_counting, 0);
      r = n_rst;
      u_cpu.mode_wr(5'h08);
      u_cpu.svc_wr(8'h00, 1'b0);
      u_cpu.svc_wr(8'hac, 1'b1);
      nc(200);
      check(20'(n_rst - r), 0);
      check(o_stopped, 1);
      end_sim();
   end
endmodule // testbench
`default_nettype wire
